// File: design/strap_pkg.sv
// constants and types shared by the strap resistor configuration decoder
package strap_pkg;

  // ==========================================================
  // clock and timing
  localparam int CLK_MHZ = 250;
  localparam int FILT_NS = 1000;
  localparam int FILT_CYC = (FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int SETTLE_US = 200;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;

  // ==========================================================
  // widths
  localparam int RES_W = 17;
  localparam int IDX_W = 4;
  localparam int ADDR_W = 7;
  localparam int MV_W = 13;
  localparam int NUM_STD = 16;

  // ==========================================================
  // address decode
  localparam logic [ADDR_W-1:0] ADDR_DEFAULT = 7'h10;
  localparam logic [ADDR_W-1:0] ADDR_BASE = 7'h10;
  localparam logic [IDX_W-1:0] HI_IDX_MAX = 4'h6;
  localparam logic [IDX_W-1:0] IDX_OPEN = 4'hf;

  // ==========================================================
  // voltage select decode
  localparam logic [MV_W-1:0] VOUT_DEFAULT_MV = 13'h0258;
  localparam logic [RES_W-1:0] VSET_SHORT_OHM = 17'h0000a;
  localparam logic [RES_W-1:0] VSET_OPEN_OHM = 17'h15f90;
  // millivolts = ohms * 4 / 75, done as a multiply and shift
  localparam logic [RES_W-1:0] VOUT_MUL = 17'h0da75;
  localparam int VOUT_SHIFT = 20;
  localparam logic CTRL_PIN_EN_DEFAULT = 1'b0;

  // ==========================================================
  // ascending standard strap values, index 0 is a short
  localparam logic [RES_W-1:0] STD_OHM [NUM_STD] = '{
    17'h00000, 17'h01a90, 17'h02008, 17'h02710,
    17'h02ee0, 17'h03a98, 17'h04650, 17'h055f0,
    17'h06978, 17'h080e8, 17'h09858, 17'h0b798,
    17'h0dac0, 17'h109a0, 17'h14050, 17'h186a0
  };

  // ==========================================================
  // sequencing states
  typedef enum logic [2:0] {
    st_idle,
    st_settle,
    st_quant,
    st_decode,
    st_run
  } cfg_state_e;

endpackage

// File: design/strap_filter.sv
// synchroniser and stability filter for one strap reading
`timescale 1ns/10ps
module strap_filter #(
  parameter int W = 17,
  parameter int LEN = 250
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic [W-1:0] i_raw,
  output logic [W-1:0] o_value,
  output logic o_stable
);

  localparam int CNT_W = $clog2(LEN);

  if (LEN < 2) begin : g_bad_len
    $error("strap_filter needs LEN of at least 2");
  end

  logic [W-1:0] sync1_reg;
  logic [W-1:0] sync2_reg;
  logic [W-1:0] cand_reg;
  logic [W-1:0] value_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic stable_reg;

  // ==========================================================
  // two-stage synchroniser
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else if (i_ce) begin
      sync1_reg <= i_raw;
      sync2_reg <= sync1_reg;
    end
  end

  // ==========================================================
  // a reading counts only after LEN + 1 equal samples; this also hides
  // bits of the word that cross the synchroniser on different edges
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cand_reg <= '0;
      cnt_reg <= '0;
    end else if (i_ce) begin
      if (sync2_reg != cand_reg) begin
        cand_reg <= sync2_reg;
        cnt_reg <= '0;
      end else if (cnt_reg != CNT_W'(LEN - 1)) begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      value_reg <= '0;
      stable_reg <= 1'b0;
    end else if (i_ce) begin
      if (sync2_reg != cand_reg) begin
        stable_reg <= 1'b0;
      end else if (cnt_reg == CNT_W'(LEN - 1)) begin
        value_reg <= cand_reg;
        stable_reg <= 1'b1;
      end
    end
  end

  assign o_value = value_reg;
  assign o_stable = stable_reg;

  // ==========================================================
  // checks
  a_filter_hold: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    !$stable(value_reg) |-> $past(cnt_reg) == CNT_W'(LEN - 1))
    else $error("filtered value moved before the reading settled");

endmodule

// File: design/strap_quantizer.sv
// maps a resistance reading to the nearest standard strap index
`timescale 1ns/10ps
module strap_quantizer (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic [strap_pkg::RES_W-1:0] i_value,
  output logic [strap_pkg::IDX_W-1:0] o_index
);
  import strap_pkg::*;

  logic [NUM_STD-2:0] above;
  logic [IDX_W-1:0] count;
  logic [IDX_W-1:0] index_reg;

  // ==========================================================
  // one comparator per boundary, at the midpoint of two neighbours
  for (genvar k = 0; k < NUM_STD - 1; k++) begin : g_cmp
    localparam logic [RES_W-1:0] MID =
      RES_W'((int'(STD_OHM[k]) + int'(STD_OHM[k + 1])) / 2);
    assign above[k] = i_value > MID;
  end

  // an open pin reads above every boundary and lands on the top index
  always_comb begin
    count = '0;
    for (int k = 0; k < NUM_STD - 1; k++) begin
      count = count + {{(IDX_W - 1){1'b0}}, above[k]};
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      index_reg <= '0;
    end else if (i_ce) begin
      index_reg <= count;
    end
  end

  assign o_index = index_reg;

  // ==========================================================
  // checks
  a_index_short: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_ce && i_value == '0) |=> index_reg == '0)
    else $error("short did not give index zero");
  a_index_open: assert property (@(posedge i_clk) disable iff (!i_arst_n)
    (i_ce && i_value > STD_OHM[NUM_STD - 1]) |=> index_reg == IDX_OPEN)
    else $error("open input did not give the top index");

endmodule

// File: design/strap_resistor_config_decoder.sv
// start-up decoder of strap resistors into bus address, vout and ctrl mode
// ==========================================================
// Contract
// - read straps only during start-up, then ignore
// - no strap detected keeps factory defaults
// - bus writes replace decoded settings afterwards
// - non-vset inputs resolve into sixteen indices
// - filter readings before decoding them
// - both address inputs open give address 16
// - high input shorted gives 16 plus low index
// - single-input addresses span 16 to 31
// - dual address is 16 times (1+high) plus low
// - decoder reaches any address 16 to 127
// - decoder never gives address below 16
// - vout is one volt per 18.75 kilohm
// - vset below 10 ohm or above 90k: 0.6 V
// - vset also picks initial ctrl pin behaviour
// - high index 7 up aliases index zero, except that an open low input gives 16
`timescale 1ns/10ps
module strap_resistor_config_decoder #(
  parameter int SETTLE_CYCLES = strap_pkg::SETTLE_CYC,
  parameter int FILT_LEN = strap_pkg::FILT_CYC
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic i_startup,
  input wire logic [strap_pkg::RES_W-1:0] i_addr_low_resistor_ohm,
  input wire logic [strap_pkg::RES_W-1:0] i_addr_high_resistor_ohm,
  input wire logic [strap_pkg::RES_W-1:0] i_vout_select_resistor_ohm,
  input wire logic i_bus_addr_we,
  input wire logic [strap_pkg::ADDR_W-1:0] i_bus_addr,
  input wire logic i_bus_vout_we,
  input wire logic [strap_pkg::MV_W-1:0] i_bus_vout_mv,
  input wire logic i_bus_ctrl_we,
  input wire logic i_bus_ctrl_pin_en,
  output logic [strap_pkg::ADDR_W-1:0] o_smbus_addr,
  output logic [strap_pkg::MV_W-1:0] o_vout_mv,
  output logic o_ctrl_pin_en,
  output logic o_cfg_valid,
  output logic o_busy
);
  import strap_pkg::*;

  localparam int TMO_W = $clog2(SETTLE_CYCLES + 1);

  if (SETTLE_CYCLES < 2 || FILT_LEN < 2 || FILT_LEN >= SETTLE_CYCLES) begin : g_bad_par
    $error("settle window must be longer than the filter length");
  end

  // ==========================================================
  // signals
  logic [RES_W-1:0] raw [3];
  logic [RES_W-1:0] filt_val [3];
  logic [2:0] filt_ok;
  logic [IDX_W-1:0] idx [2];

  cfg_state_e state_reg;
  logic startup_q_reg;
  logic [TMO_W-1:0] tmo_reg;
  logic [IDX_W-1:0] lo_idx_reg;
  logic [IDX_W-1:0] hi_idx_reg;
  logic [RES_W-1:0] vset_reg;
  logic [ADDR_W-1:0] addr_reg;
  logic [MV_W-1:0] vout_reg;
  logic ctrl_reg;
  logic valid_reg;
  logic busy_reg;

  logic start_edge;
  logic all_ok;
  logic tmo_done;
  logic settle_end;
  logic vset_ok;
  logic [2*RES_W-1:0] prod;
  logic [ADDR_W-1:0] addr_dec;
  logic [MV_W-1:0] vout_dec;

  assign raw[0] = i_addr_low_resistor_ohm;
  assign raw[1] = i_addr_high_resistor_ohm;
  assign raw[2] = i_vout_select_resistor_ohm;

  // ==========================================================
  // per-input synchroniser and filter, plus a quantiser on each address input
  for (genvar ch = 0; ch < 3; ch++) begin : g_ch
    strap_filter #(
      .W(RES_W),
      .LEN(FILT_LEN)
    ) u_filt (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_ce(i_ce),
      .i_raw(raw[ch]),
      .o_value(filt_val[ch]),
      .o_stable(filt_ok[ch])
    );
    // vset is continuous, so only the address inputs are indexed
    if (ch < 2) begin : g_q
      strap_quantizer u_quant (
        .i_clk(i_clk),
        .i_arst_n(i_arst_n),
        .i_ce(i_ce),
        .i_value(filt_val[ch]),
        .o_index(idx[ch])
      );
    end
  end

  // ==========================================================
  // sequencing
  assign start_edge = i_startup && !startup_q_reg;
  assign all_ok = &filt_ok;
  assign tmo_done = tmo_reg == TMO_W'(SETTLE_CYCLES - 1);
  assign settle_end = !i_startup || tmo_done;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      startup_q_reg <= 1'b0;
    end else if (i_ce) begin
      startup_q_reg <= i_startup;
    end
  end

  // a reading that never settles inside the window leaves the defaults
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_reg <= st_idle;
    end else if (i_ce) begin
      if (start_edge) begin
        state_reg <= st_settle;
      end else begin
        case (state_reg)
          st_settle: begin
            if (settle_end) begin
              state_reg <= st_run;
            end else if (all_ok) begin
              state_reg <= st_quant;
            end
          end
          st_quant: state_reg <= st_decode;
          st_decode: state_reg <= st_run;
          st_idle: state_reg <= st_idle;
          st_run: state_reg <= st_run;
          default: state_reg <= st_idle;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tmo_reg <= '0;
    end else if (i_ce) begin
      if (start_edge) begin
        tmo_reg <= '0;
      end else if (state_reg == st_settle && !tmo_done) begin
        tmo_reg <= tmo_reg + 1'b1;
      end
    end
  end

  // ==========================================================
  // capture of settled readings
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      vset_reg <= '0;
    end else if (i_ce && state_reg == st_settle && !settle_end && all_ok) begin
      vset_reg <= filt_val[2];
    end
  end

  // quantiser output here reflects the readings seen when all settled
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lo_idx_reg <= '0;
      hi_idx_reg <= '0;
    end else if (i_ce && state_reg == st_quant) begin
      lo_idx_reg <= idx[0];
      hi_idx_reg <= idx[1];
    end
  end

  // ==========================================================
  // decode
  always_comb begin
    if (hi_idx_reg <= HI_IDX_MAX) begin
      addr_dec = ADDR_BASE + {hi_idx_reg[2:0], 4'h0} + ADDR_W'(lo_idx_reg);
    end else if (lo_idx_reg == IDX_OPEN) begin
      addr_dec = ADDR_DEFAULT;
    end else begin
      addr_dec = ADDR_BASE + ADDR_W'(lo_idx_reg);
    end
  end

  assign vset_ok = vset_reg >= VSET_SHORT_OHM && vset_reg <= VSET_OPEN_OHM;
  assign prod = (2*RES_W)'(vset_reg) * (2*RES_W)'(VOUT_MUL);
  assign vout_dec = vset_ok ? prod[VOUT_SHIFT +: MV_W] : VOUT_DEFAULT_MV;

  // ==========================================================
  // settings: defaults at start-up, decode once, then bus only
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      addr_reg <= ADDR_DEFAULT;
    end else if (i_ce) begin
      if (start_edge) begin
        addr_reg <= ADDR_DEFAULT;
      end else if (state_reg == st_decode) begin
        addr_reg <= addr_dec;
      end else if (state_reg == st_run && i_bus_addr_we) begin
        addr_reg <= i_bus_addr;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      vout_reg <= VOUT_DEFAULT_MV;
    end else if (i_ce) begin
      if (start_edge) begin
        vout_reg <= VOUT_DEFAULT_MV;
      end else if (state_reg == st_decode) begin
        vout_reg <= vout_dec;
      end else if (state_reg == st_run && i_bus_vout_we) begin
        vout_reg <= i_bus_vout_mv;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctrl_reg <= CTRL_PIN_EN_DEFAULT;
    end else if (i_ce) begin
      if (start_edge) begin
        ctrl_reg <= CTRL_PIN_EN_DEFAULT;
      end else if (state_reg == st_decode) begin
        ctrl_reg <= vset_ok;
      end else if (state_reg == st_run && i_bus_ctrl_we) begin
        ctrl_reg <= i_bus_ctrl_pin_en;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      valid_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else if (i_ce) begin
      if (start_edge) begin
        valid_reg <= 1'b0;
        busy_reg <= 1'b1;
      end else if (state_reg == st_decode || (state_reg == st_settle && settle_end)) begin
        valid_reg <= 1'b1;
        busy_reg <= 1'b0;
      end
    end
  end

  assign o_smbus_addr = addr_reg;
  assign o_vout_mv = vout_reg;
  assign o_ctrl_pin_en = ctrl_reg;
  assign o_cfg_valid = valid_reg;
  assign o_busy = busy_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_arst_n);

  a_addr_reserved: assert property (
    (i_ce && state_reg == st_decode) |=> addr_reg >= ADDR_BASE)
    else $error("decoded address fell in the reserved range");

  a_addr_single: assert property (
    (i_ce && state_reg == st_decode && hi_idx_reg == '0)
    |=> addr_reg == ADDR_BASE + ADDR_W'($past(lo_idx_reg)))
    else $error("single-input address is not 16 plus low index");

  a_single_span: assert property (
    (i_ce && state_reg == st_decode && hi_idx_reg == '0) |=> addr_reg[6:4] == 3'h1)
    else $error("single-input address left the 16 to 31 span");

  a_addr_dual: assert property (
    (i_ce && state_reg == st_decode && hi_idx_reg <= HI_IDX_MAX)
    |=> addr_reg[3:0] == $past(lo_idx_reg)
        && addr_reg[6:4] == $past(hi_idx_reg[2:0]) + 3'h1)
    else $error("dual-input address formula broken");

  a_addr_alias: assert property (
    (i_ce && state_reg == st_decode && hi_idx_reg > HI_IDX_MAX)
    |=> addr_reg == (($past(lo_idx_reg) == IDX_OPEN) ? ADDR_DEFAULT
                     : ADDR_BASE + ADDR_W'($past(lo_idx_reg))))
    else $error("high index above six did not alias index zero");

  a_vout_default: assert property (
    (i_ce && state_reg == st_decode && (vset_reg < VSET_SHORT_OHM || vset_reg > VSET_OPEN_OHM))
    |=> vout_reg == VOUT_DEFAULT_MV)
    else $error("out-of-range vset did not keep the default set-point");

  a_vout_scale: assert property (
    (i_ce && state_reg == st_decode && vset_ok)
    |=> vout_reg == $past(prod[VOUT_SHIFT +: MV_W]))
    else $error("vout set-point not proportional to vset");

  a_ctrl_follow: assert property (
    (i_ce && state_reg == st_decode) |=> ctrl_reg == $past(vset_ok))
    else $error("ctrl pin mode not taken from vset");

  a_ignore_after: assert property (
    (i_ce && state_reg == st_run && !start_edge
     && !i_bus_addr_we && !i_bus_vout_we && !i_bus_ctrl_we)
    |=> $stable(addr_reg) && $stable(vout_reg) && $stable(ctrl_reg))
    else $error("settings moved after start-up without a bus write");

  a_bus_write: assert property (
    (i_ce && state_reg == st_run && !start_edge && i_bus_addr_we)
    |=> addr_reg == $past(i_bus_addr))
    else $error("bus write did not replace the address");

  a_default_open: assert property (
    (i_ce && state_reg == st_decode && hi_idx_reg == IDX_OPEN && lo_idx_reg == IDX_OPEN)
    |=> addr_reg == ADDR_DEFAULT)
    else $error("both inputs open did not give the default address");

  a_settle_bound: assert property (
    (i_ce && state_reg == st_settle && tmo_done && !start_edge) |=> state_reg == st_run)
    else $error("settle window overran");

  c_decode_done: cover property (state_reg == st_decode ##1 state_reg == st_run);
  c_timeout: cover property (state_reg == st_settle && tmo_done && i_ce);
  c_bus_write: cover property (state_reg == st_run && i_bus_vout_we && i_ce);
  c_alias: cover property (state_reg == st_decode && hi_idx_reg > HI_IDX_MAX);

endmodule

// File: verification/strap_model.sv
// strap resistor model presenting measured readings at the configuration pins
`timescale 1ns/10ps
module strap_model (
  input wire logic i_clk,
  input wire logic i_noisy,
  input wire logic [strap_pkg::RES_W-1:0] i_low_ohm,
  input wire logic [strap_pkg::RES_W-1:0] i_high_ohm,
  input wire logic [strap_pkg::RES_W-1:0] i_vset_ohm,
  output logic [strap_pkg::RES_W-1:0] o_low_ohm,
  output logic [strap_pkg::RES_W-1:0] o_high_ohm,
  output logic [strap_pkg::RES_W-1:0] o_vset_ohm
);
  import strap_pkg::*;
  // ==========================================================
  // noise source
  logic flip_reg = 1'b0;
  always_ff @(posedge i_clk) begin
    flip_reg <= ~flip_reg;
  end
  // every bit flips each cycle, so no reading ever stays equal long enough
  assign o_low_ohm = (i_noisy && flip_reg) ? ~i_low_ohm : i_low_ohm;
  assign o_high_ohm = (i_noisy && flip_reg) ? ~i_high_ohm : i_high_ohm;
  assign o_vset_ohm = (i_noisy && flip_reg) ? ~i_vset_ohm : i_vset_ohm;
endmodule

// File: verification/strap_resistor_config_decoder_tb_top.sv
// self-checking bench of the strap resistor configuration decoder
`timescale 1ns/10ps
module strap_resistor_config_decoder_tb_top;
  import strap_pkg::*;
  // ==========================================================
  // signals
  localparam int SETTLE = 400;
  localparam int FLEN = 4;
  localparam logic [RES_W-1:0] OPEN = 17'h1ffff;
  localparam int MID [15] = '{3400, 7500, 9100, 11000, 13500, 16500, 20000, 24500,
    30000, 36000, 43000, 51500, 62000, 75000, 91000};
  localparam logic [RES_W-1:0] VS_EDGE [7] = '{17'h00000, 17'h00009, 17'h0000a,
    17'h0493e, 17'h15f90, 17'h15f91, 17'h1ffff};
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_startup = 1'b0;
  logic noisy = 1'b0;
  logic ce = 1'b1;
  logic [RES_W-1:0] lo_ohm = '0;
  logic [RES_W-1:0] hi_ohm = '0;
  logic [RES_W-1:0] vs_ohm = '0;
  logic [RES_W-1:0] lo_pin;
  logic [RES_W-1:0] hi_pin;
  logic [RES_W-1:0] vs_pin;
  logic addr_we = 1'b0;
  logic [ADDR_W-1:0] addr_val = '0;
  logic vout_we = 1'b0;
  logic [MV_W-1:0] vout_val = '0;
  logic ctrl_we = 1'b0;
  logic ctrl_val = 1'b0;
  logic [ADDR_W-1:0] o_smbus_addr;
  logic [MV_W-1:0] o_vout_mv;
  logic o_ctrl_pin_en;
  logic o_cfg_valid;
  logic o_busy;
  int error_cnt = 0;
  int total_checks = 0;
  logic [31:0] seed = 32'hcf37f87c;
  always #2 i_clk = ~i_clk;
  // ==========================================================
  // instances
  strap_model strap_model_inst (.i_clk(i_clk), .i_noisy(noisy), .i_low_ohm(lo_ohm),
    .i_high_ohm(hi_ohm), .i_vset_ohm(vs_ohm), .o_low_ohm(lo_pin), .o_high_ohm(hi_pin),
    .o_vset_ohm(vs_pin));
  strap_resistor_config_decoder #(.SETTLE_CYCLES(SETTLE), .FILT_LEN(FLEN))
    strap_resistor_config_decoder_inst (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_ce(ce),
    .i_startup(i_startup), .i_addr_low_resistor_ohm(lo_pin),
    .i_addr_high_resistor_ohm(hi_pin), .i_vout_select_resistor_ohm(vs_pin),
    .i_bus_addr_we(addr_we), .i_bus_addr(addr_val), .i_bus_vout_we(vout_we),
    .i_bus_vout_mv(vout_val), .i_bus_ctrl_we(ctrl_we), .i_bus_ctrl_pin_en(ctrl_val),
    .o_smbus_addr(o_smbus_addr), .o_vout_mv(o_vout_mv), .o_ctrl_pin_en(o_ctrl_pin_en),
    .o_cfg_valid(o_cfg_valid), .o_busy(o_busy));
  // ==========================================================
  // expectation functions
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [RES_W-1:0] rnd_ohm();
    logic [31:0] v;
    v = xs();
    if (v[2:0] == 3'h0) begin
      return OPEN;
    end
    return RES_W'(v[31:8] % 100001);
  endfunction
  function automatic int idx(input logic [RES_W-1:0] r);
    int n;
    n = 0;
    foreach (MID[k]) begin
      if (r > MID[k]) begin
        n++;
      end
    end
    return n;
  endfunction
  function automatic logic [31:0] exp_addr(input logic [RES_W-1:0] lo, input logic [RES_W-1:0] hi);
    int l;
    int h;
    l = idx(lo);
    h = idx(hi);
    if (h <= 6) begin
      return 16 * (1 + h) + l;
    end
    return (l == 15) ? 16 : 16 + l;
  endfunction
  function automatic logic [31:0] vok(input logic [RES_W-1:0] r);
    return (r >= 10 && r <= 90000) ? 1 : 0;
  endfunction
  function automatic logic [31:0] exp_vout(input logic [RES_W-1:0] r);
    logic [63:0] p;
    p = 64'(r) * 64'd55925;
    return (vok(r) == 1) ? 32'(p >> 20) : 600;
  endfunction
  // ==========================================================
  // tasks
  task automatic tick();
    @(posedge i_clk);
    #1;
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic check_cfg(input logic [RES_W-1:0] lo, input logic [RES_W-1:0] hi,
    input logic [RES_W-1:0] vs);
    check("smbus_addr", 32'(o_smbus_addr), exp_addr(lo, hi));
    check("addr_floor", 32'(o_smbus_addr >= 7'h10), 1);
    check("vout_mv", 32'(o_vout_mv), exp_vout(vs));
    check("ctrl_pin_en", 32'(o_ctrl_pin_en), vok(vs));
  endtask
  // straps settle before the start edge so a stale filter cannot be decoded
  task automatic startup(input logic [RES_W-1:0] lo, input logic [RES_W-1:0] hi,
    input logic [RES_W-1:0] vs, input logic g);
    int n;
    lo_ohm = lo;
    hi_ohm = hi;
    vs_ohm = vs;
    noisy = g;
    repeat (FLEN + 8) tick();
    i_startup = 1'b1;
    tick();
    check("busy", 32'(o_busy), 1);
    check("cfg_valid", 32'(o_cfg_valid), 0);
    n = 0;
    while (o_cfg_valid !== 1'b1 && n < 1000) begin
      // random freeze cycles stretch the decode; noisy runs stay enabled
      ce = g || (xs() & 32'h3) != 32'h0;
      tick();
      n++;
    end
    ce = 1'b1;
    if (n >= 1000) begin
      error_cnt++;
      $display("ERROR cfg_valid expected 1 seen timeout");
      report_and_stop();
    end
    check("busy_done", 32'(o_busy), 0);
    i_startup = 1'b0;
    noisy = 1'b0;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    logic [RES_W-1:0] a;
    logic [RES_W-1:0] b;
    logic [RES_W-1:0] c;
    repeat (12) tick();
    i_arst_n = 1'b1;
    tick();
    check_cfg(OPEN, OPEN, OPEN);
    addr_val = 7'h55;
    addr_we = 1'b1;
    tick();
    addr_we = 1'b0;
    tick();
    check("addr_no_run", 32'(o_smbus_addr), 16);
    startup(OPEN, OPEN, OPEN, 1'b0);
    check("addr_open", 32'(o_smbus_addr), 16);
    for (int k = 0; k < NUM_STD; k++) begin
      startup(STD_OHM[k], 17'h00000, rnd_ohm(), 1'b0);
      check("addr_single", 32'(o_smbus_addr), 16 + k);
      check_cfg(STD_OHM[k], 17'h00000, vs_ohm);
    end
    for (int k = 0; k < NUM_STD; k++) begin
      a = (k[0]) ? STD_OHM[15] : rnd_ohm();
      startup(a, STD_OHM[k], rnd_ohm(), 1'b0);
      check_cfg(a, STD_OHM[k], vs_ohm);
    end
    startup(STD_OHM[15], STD_OHM[6], 17'h00000, 1'b0);
    check("addr_top", 32'(o_smbus_addr), 127);
    foreach (VS_EDGE[k]) begin
      startup(STD_OHM[2], STD_OHM[1], VS_EDGE[k], 1'b0);
      check_cfg(STD_OHM[2], STD_OHM[1], VS_EDGE[k]);
    end
    for (int k = 0; k < 24; k++) begin
      a = rnd_ohm();
      b = rnd_ohm();
      c = rnd_ohm();
      startup(a, b, c, 1'b0);
      check_cfg(a, b, c);
      check("addr_index", 32'(o_smbus_addr[3:0]), 32'(exp_addr(a, b) % 16));
    end
    // readings that never settle must fall back to defaults at the timeout
    startup(STD_OHM[3], STD_OHM[2], 17'h0493e, 1'b1);
    check_cfg(OPEN, OPEN, OPEN);
    startup(STD_OHM[5], STD_OHM[1], 17'h04e20, 1'b0);
    lo_ohm = STD_OHM[9];
    hi_ohm = STD_OHM[4];
    vs_ohm = 17'h0a000;
    repeat (FLEN + 20) tick();
    check_cfg(STD_OHM[5], STD_OHM[1], 17'h04e20);
    addr_val = 7'(xs()) | 7'h40;
    addr_we = 1'b1;
    ce = 1'b0;
    tick();
    check("addr_frozen", 32'(o_smbus_addr), exp_addr(STD_OHM[5], STD_OHM[1]));
    ce = 1'b1;
    tick();
    addr_we = 1'b0;
    check("bus_addr", 32'(o_smbus_addr), 32'(addr_val));
    vout_val = 13'(xs());
    vout_we = 1'b1;
    tick();
    vout_we = 1'b0;
    check("bus_vout", 32'(o_vout_mv), 32'(vout_val));
    ctrl_val = 1'b0;
    ctrl_we = 1'b1;
    tick();
    ctrl_we = 1'b0;
    check("bus_ctrl", 32'(o_ctrl_pin_en), 0);
    startup(lo_ohm, hi_ohm, vs_ohm, 1'b0);
    check_cfg(STD_OHM[9], STD_OHM[4], 17'h0a000);
    report_and_stop();
  end
endmodule
